// ### core/ssr_pulse_div.sv
// module: one free running half-period toggler on the millisecond tick
`timescale 1ns/1ps
module ssr_pulse_div #(
   parameter int unsigned HALF_MS = 5
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic ce,
   // shared millisecond tick
   input wire logic ms_tick,
   // square wave out
   output logic pulse_q
);
   localparam int unsigned CW = $clog2(HALF_MS + 1);
   localparam logic [CW-1:0] LAST = CW'(HALF_MS - 1);

   logic [CW-1:0] cnt_q;
   wire logic at_last = (cnt_q == LAST);

   //===================================================================
   // count ticks and flip at each half period
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= '0;
         pulse_q <= 1'b0;
      end else if (ce && ms_tick) begin
         cnt_q <= at_last ? '0 : cnt_q + 1'b1;
         if (at_last) begin
            pulse_q <= ~pulse_q; // equal on and off phases
         end
      end
   end
endmodule

// ### core/ssr_relays.sv
// module: special status and control relays with an Avalon-MM register port
`timescale 1ns/1ps
module ssr_relays import ssr_pkg::*; #(
   parameter int unsigned MS_DIV = MS_CYCLES,
   parameter int unsigned OUT_N = 16
) (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic ce,
   // avalon-mm slave
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // pins from outside the clock domain
   input wire logic batt_low_pin,
   input wire logic rtc_err_pin,
   // controller core, same clock
   input wire logic run,
   input wire ssr_arith_t arith,
   input wire logic multi_scan_done,
   input wire logic net_param_set,
   input wire logic xfer_busy,
   input wire logic scan_end,
   input wire logic [OUT_N-1:0] out_image,
   // relay outputs
   output logic [PULSE_N-1:0] pulses,
   output logic rtc_installed,
   output logic batt_lamp,
   output logic irq_allow,
   output logic clear_volatile,
   output logic clear_retained,
   output logic reset_mem_stop,
   output logic scan_start,
   output logic [OUT_N-1:0] out_pins_q
);
   //===================================================================
   // byte lane mask, used by the control, scan time and clock registers; the sticky clear reads byteenable[0] directly
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   localparam int unsigned MSW = $clog2(MS_DIV + 1);
   localparam logic [MSW-1:0] MS_LAST = MSW'(MS_DIV - 1);
   localparam int unsigned HALF[PULSE_N] = '{HALF_10MS, HALF_100MS,
      HALF_1S, HALF_1MIN};

   //===================================================================
   // state
   logic [MSW-1:0] ms_cnt_q;
   logic ms_tick_q;
   logic [1:0] sync1_q;
   logic [1:0] sync2_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic [CTRL_W-1:0] ctrl_q;
   logic [15:0] scan_time_q;
   logic [5:0] sec_q;
   logic [10:0] min_q;
   logic [16:0] disp_q;
   logic sec_prev_q;
   logic fault_q;
   logic done_q;
   logic zero_q;
   logic borrow_q;
   logic carry_q;
   logic run_q;
   logic stop_pulse_q;
   logic [15:0] elapsed_q;
   ssr_scan_t scan_q;
   ssr_scan_t scan_d;
   logic [OUT_N-1:0] out_d;

   //===================================================================
   // free running millisecond base, not tied to the scan state
   wire logic ms_wrap = (ms_cnt_q == MS_LAST);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ms_cnt_q <= '0;
         ms_tick_q <= 1'b0;
      end else if (ce) begin
         ms_cnt_q <= ms_wrap ? '0 : ms_cnt_q + 1'b1;
         ms_tick_q <= ms_wrap;
      end
   end

   // four pulse relays share the one tick so their edges stay aligned
   genvar gi;
   generate
      for (gi = 0; gi < PULSE_N; gi++) begin : g_pulse
         ssr_pulse_div #(
            .HALF_MS(HALF[gi])
         ) u_div (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .ce(ce),
            .ms_tick(ms_tick_q),
            .pulse_q(pulses[gi])
         );
      end
   endgenerate

   //===================================================================
   // two-stage synchronisers for the battery and clock fault pins
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
      end else if (ce) begin
         sync1_q <= {rtc_err_pin, batt_low_pin};
         sync2_q <= sync1_q;
      end
   end

   wire logic batt_low_s = sync2_q[0];
   wire logic rtc_err_s = sync2_q[1];

   //===================================================================
   // bus decode: one wait cycle, answer on the second edge
   wire logic req = (read | write) & ~ack_q;
   wire logic wr_go = write & ack_q;
   wire logic [31:0] wmask = lane_mask(byteenable);
   wire logic [31:0] wd_ctrl = ({18'h0, ctrl_q} & ~wmask) | (writedata & wmask);
   wire logic [31:0] wd_scan = ({16'h0, scan_time_q} & ~wmask) | (writedata & wmask);
   wire logic [31:0] wd_rtc = ({15'h0, min_q, sec_q} & ~wmask) | (writedata & wmask);
   wire logic wr_ctrl = wr_go & (address == OFS_CTRL);
   wire logic wr_sticky = wr_go & (address == OFS_STICKY);
   wire logic wr_scan = wr_go & (address == OFS_SCAN);
   wire logic wr_rtc = wr_go & (address == OFS_RTC);

   // a frozen enable keeps the master waiting, so no write is dropped
   assign waitrequest = (read | write) & ~(ack_q & ce);
   assign readdata = rdata_q;

   // live status word
   wire logic [31:0] status_w = {20'h0, run_q, net_param_set, done_q,
      carry_q, borrow_q, zero_q, fault_q, rtc_installed, pulses};

   // read mux; unmapped offsets answer zero
   wire logic [31:0] rd_mux =
      (address == OFS_CTRL) ? {18'h0, ctrl_q} :
      (address == OFS_STATUS) ? status_w :
      (address == OFS_STICKY) ? {30'h0, done_q, fault_q} :
      (address == OFS_SCAN) ? {16'h0, scan_time_q} :
      (address == OFS_RTC) ? {15'h0, disp_q} : 32'h0000_0000;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else if (ce) begin
         ack_q <= req;
         if (req && read) begin
            rdata_q <= rd_mux;
         end
      end
   end

   //===================================================================
   // run to stop edge, shared by the mode bits and memory hold
   wire logic stop_edge = run_q & ~run;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         run_q <= 1'b0;
         stop_pulse_q <= 1'b0;
      end else if (ce) begin
         run_q <= run;
         stop_pulse_q <= stop_edge & ~ctrl_q[C_HOLD];
      end
   end

   assign reset_mem_stop = stop_pulse_q;

   //===================================================================
   // control register; the round bit clears itself once applied
   wire logic round_go = ctrl_q[C_ROUND];
   wire logic [CTRL_W-1:0] ctrl_wr = wr_ctrl ? wd_ctrl[CTRL_W-1:0] : ctrl_q;
   wire logic [CTRL_W-1:0] ctrl_rnd = round_go ?
      (ctrl_wr & ~(CTRL_W'(1) << C_ROUND)) : ctrl_wr;
   // a stop edge wins over a write of the same cycle
   wire logic [CTRL_W-1:0] ctrl_d = stop_edge ?
      (ctrl_rnd & ~STOP_CLR_MASK) : ctrl_rnd;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= CTRL_RESET;
      end else if (ce) begin
         ctrl_q <= ctrl_d;
      end
   end

   //===================================================================
   // real time clock, minutes and seconds of the day
   wire logic sec_edge = pulses[2] & ~sec_prev_q;
   wire logic sec_wrap = (sec_q == SEC_MAX);
   wire logic min_wrap = (min_q == MIN_MAX);
   wire logic [10:0] min_inc = min_wrap ? 11'h000 : min_q + 11'h001;
   wire logic round_up = (sec_q >= SEC_HALF);
   wire logic bad_time = (sec_q > SEC_MAX) | (min_q > MIN_MAX);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sec_prev_q <= 1'b0;
      end else if (ce) begin
         sec_prev_q <= pulses[2];
      end
   end

   // stop halts counting; preset is only taken while stopped
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sec_q <= 6'h00;
         min_q <= 11'h000;
      end else if (ce) begin
         if (wr_rtc && ctrl_q[C_STOP]) begin
            sec_q <= wd_rtc[5:0];
            min_q <= wd_rtc[16:6];
         end else if (round_go) begin
            sec_q <= 6'h00;
            min_q <= round_up ? min_inc : min_q;
         end else if (sec_edge && !ctrl_q[C_STOP]) begin
            sec_q <= sec_wrap ? 6'h00 : sec_q + 6'h01;
            min_q <= sec_wrap ? min_inc : min_q;
         end
      end
   end

   // shown reading tracks the clock unless frozen
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         disp_q <= 17'h00000;
      end else if (ce && !ctrl_q[C_FREEZE]) begin
         disp_q <= {min_q, sec_q};
      end
   end

   assign rtc_installed = 1'b1;

   //===================================================================
   // sticky flags: hardware set wins over a write-one clear
   wire logic fault_set = rtc_err_s | bad_time;
   wire logic fault_clr = wr_sticky & byteenable[0] & writedata[0];
   wire logic done_clr = wr_sticky & byteenable[0] & writedata[1];

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         fault_q <= 1'b0;
         done_q <= 1'b0;
      end else if (ce) begin
         fault_q <= fault_set | (fault_q & ~fault_clr);
         done_q <= multi_scan_done | (done_q & ~done_clr);
      end
   end

   //===================================================================
   // arithmetic flags follow the last reported result
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         zero_q <= 1'b0;
         borrow_q <= 1'b0;
         carry_q <= 1'b0;
      end else if (ce && arith.valid) begin
         zero_q <= arith.zero;
         borrow_q <= arith.borrow;
         carry_q <= arith.carry;
      end
   end

   //===================================================================
   // mode outputs toward the controller core
   assign batt_lamp = batt_low_s & ~ctrl_q[C_LAMP];
   assign irq_allow = ~xfer_busy | ctrl_q[C_IRQX];
   // only image and data memory are cleared; no file register path exists
   assign clear_volatile = ctrl_q[C_VCLR];
   assign clear_retained = ctrl_q[C_RCLR];

   // outputs are registered so a disable never glitches a contact
   assign out_d = ctrl_q[C_OFF] ? '0 : out_image;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         out_pins_q <= '0;
      end else if (ce) begin
         out_pins_q <= out_d;
      end
   end

   //===================================================================
   // scan time register in milliseconds
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         scan_time_q <= SCAN_RESET;
      end else if (ce && wr_scan) begin
         scan_time_q <= wd_scan[15:0];
      end
   end

   // elapsed time since the last scan start, saturating
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         elapsed_q <= 16'h0000;
      end else if (ce) begin
         if (scan_q == SC_START) begin
            elapsed_q <= 16'h0000;
         end else if (ms_tick_q && elapsed_q != 16'hffff) begin
            elapsed_q <= elapsed_q + 16'h0001;
         end
      end
   end

   wire logic time_up = ~ctrl_q[C_FSCAN] | (elapsed_q >= scan_time_q);

   // next scan is held back until the fixed scan time has passed
   always_comb begin
      scan_d = scan_q;
      case (scan_q)
         SC_RUN: begin
            if (scan_end) begin
               scan_d = time_up ? SC_START : SC_WAIT;
            end
         end
         SC_WAIT: begin
            if (time_up) begin
               scan_d = SC_START;
            end
         end
         SC_START: begin
            scan_d = SC_RUN;
         end
         default: begin
            scan_d = SC_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         scan_q <= SC_RUN;
      end else if (ce) begin
         scan_q <= scan_d;
      end
   end

   assign scan_start = (scan_q == SC_START);

   // network parameter flag is mirrored live in the status word,
   // at bit 10 beside the run monitor
endmodule

// ### shared/ssr_pkg.sv
// package: constants and types of the special status relay block
//======================================================================
package ssr_pkg;
   //===================================================================
   // time base
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned MS_PERIOD_NS = 1000000;
   localparam int unsigned MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
   // pulse relay half periods, in milliseconds
   localparam int unsigned HALF_10MS = 5;
   localparam int unsigned HALF_100MS = 50;
   localparam int unsigned HALF_1S = 500;
   localparam int unsigned HALF_1MIN = 30000;
   localparam int unsigned PULSE_N = 4;
   //===================================================================
   // clock limits
   localparam logic [5:0] SEC_MAX = 6'h3b;
   localparam logic [5:0] SEC_HALF = 6'h1e;
   localparam logic [10:0] MIN_MAX = 11'h59f;
   //===================================================================
   // register byte offsets
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_STATUS = 5'h04;
   localparam logic [4:0] OFS_STICKY = 5'h08;
   localparam logic [4:0] OFS_SCAN = 5'h0c;
   localparam logic [4:0] OFS_RTC = 5'h10;
   // control bit positions
   localparam int unsigned C_STOP = 0;
   localparam int unsigned C_FREEZE = 1;
   localparam int unsigned C_ROUND = 2;
   localparam int unsigned C_BLOCK_MOVE_INSTR = 3;
   localparam int unsigned C_FCNT = 4;
   localparam int unsigned C_SLOPE = 5;
   localparam int unsigned C_PRINT = 6;
   localparam int unsigned C_IRQX = 7;
   localparam int unsigned C_LAMP = 8;
   localparam int unsigned C_VCLR = 9;
   localparam int unsigned C_RCLR = 10;
   localparam int unsigned C_HOLD = 11;
   localparam int unsigned C_OFF = 12;
   localparam int unsigned C_FSCAN = 13;
   localparam int unsigned CTRL_W = 14;
   // bits cleared on run to stop
   localparam logic [13:0] STOP_CLR_MASK = 14'h1778;
   localparam logic [13:0] CTRL_RESET = 14'h0000;
   localparam logic [15:0] SCAN_RESET = 16'h0000;
   //===================================================================
   // arithmetic result reported by the instruction unit
   typedef struct packed {
      logic valid;
      logic zero;
      logic borrow;
      logic carry;
   } ssr_arith_t;
   // constant scan sequencer
   typedef enum logic [1:0] {
      SC_RUN = 2'b00,
      SC_WAIT = 2'b01,
      SC_START = 2'b11
   } ssr_scan_t;
endpackage

// ### verification/ssr_relays_properties.sv
// checker: port-level properties of the special status relay block
`timescale 1ns/1ps
module ssr_relays_chk import ssr_pkg::*; #(
   parameter int unsigned MS_DIV = MS_CYCLES,
   parameter int unsigned OUT_N = 16
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic ce,
   // inputs watched
   input wire logic read,
   input wire logic batt_low_pin,
   input wire logic run,
   input wire logic xfer_busy,
   input wire logic [OUT_N-1:0] out_image,
   // outputs watched
   input wire logic waitrequest,
   input wire logic [PULSE_N-1:0] pulses,
   input wire logic rtc_installed,
   input wire logic batt_lamp,
   input wire logic irq_allow,
   input wire logic clear_volatile,
   input wire logic clear_retained,
   input wire logic reset_mem_stop,
   input wire logic scan_start,
   input wire logic [OUT_N-1:0] out_pins_q
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   //===================================================================
   // half period meters
   logic [31:0] cnt_q [3];
   logic [2:0] prev_q;
   logic [2:0] seen_q;
   // ce-high edges since each of the 10 ms, 100 ms and 1 s relays last moved; the first move after reset is
   // skipped because its phase to the release is not a full half period
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prev_q <= 3'h0;
         seen_q <= 3'h0;
         for (int i = 0; i < 3; i++) cnt_q[i] <= 32'h0;
      end else begin
         prev_q <= pulses[2:0];
         seen_q <= seen_q | (pulses[2:0] ^ prev_q);
         for (int i = 0; i < 3; i++) begin
            cnt_q[i] <= (pulses[i] != prev_q[i]) ? {31'h0, ce} : cnt_q[i] + {31'h0, ce};
         end
      end
   end
   //===================================================================
   // properties
   property p_p10;
      (pulses[0] != prev_q[0]) && seen_q[0] |-> cnt_q[0] == HALF_10MS * MS_DIV;
   endproperty
   a_p10: assert property (p_p10) else $error("10 ms relay half period wrong");
   property p_p100;
      (pulses[1] != prev_q[1]) && seen_q[1] |-> cnt_q[1] == HALF_100MS * MS_DIV;
   endproperty
   a_p100: assert property (p_p100) else $error("100 ms relay half period wrong");
   property p_p1s;
      (pulses[2] != prev_q[2]) && seen_q[2] |-> cnt_q[2] == HALF_1S * MS_DIV;
   endproperty
   a_p1s: assert property (p_p1s) else $error("1 s relay half period wrong");
   property p_inst; rtc_installed; endproperty
   a_inst: assert property (p_inst) else $error("clock installed relay low");
   property p_lamp; batt_lamp |-> $past(batt_low_pin, 2); endproperty
   a_lamp: assert property (p_lamp) else $error("lamp lit without low battery");
   property p_irq; !xfer_busy |-> irq_allow; endproperty
   a_irq: assert property (p_irq) else $error("interrupts blocked while idle");
   property p_outs;
      (out_pins_q != '0) && $past(ce) |-> out_pins_q == $past(out_image);
   endproperty
   a_outs: assert property (p_outs) else $error("outputs differ from image");
   property p_hold; reset_mem_stop |-> !$past(run) && ($past(run, 2) || $past(run, 3)); endproperty
   a_hold: assert property (p_hold) else $error("memory reset without stop");
   property p_stop; $fell(run) |-> ##[1:3] (!clear_volatile && !clear_retained); endproperty
   a_stop: assert property (p_stop) else $error("clear bits survive stop");
   property p_bus; $rose(read) && ce |-> waitrequest ##1 !waitrequest; endproperty
   a_bus: assert property (p_bus) else $error("read not answered after one wait");
   property p_scan; scan_start |=> !scan_start; endproperty
   a_scan: assert property (p_scan) else $error("scan start longer than one cycle");
endmodule

bind ssr_relays ssr_relays_chk #(.MS_DIV(MS_DIV), .OUT_N(OUT_N)) ssr_relays_chk_i (
   .ref_clk, .nrst, .ce, .read, .batt_low_pin, .run, .xfer_busy, .out_image, .waitrequest,
   .pulses, .rtc_installed, .batt_lamp, .irq_allow, .clear_volatile, .clear_retained,
   .reset_mem_stop, .scan_start, .out_pins_q
);

// ### verification/tb_top.sv
// testbench: self-checking run of the special status relay block
`timescale 1ns/1ps
module tb_top;
   import ssr_pkg::*;
   localparam int unsigned DIV = 10;
   localparam int LIMIT = 30000;
   typedef struct {logic [31:0] v; logic [31:0] m;} ssr_note_t;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [4:0] address = 5'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic batt_low_pin = 1'b0, rtc_err_pin = 1'b0, run = 1'b0, multi_scan_done = 1'b0;
   logic net_param_set = 1'b0, xfer_busy = 1'b0, scan_end = 1'b0;
   ssr_arith_t arith = '0;
   logic [15:0] out_image = 16'h0;
   logic [31:0] readdata;
   logic [3:0] pulses;
   logic [15:0] out_pins_q;
   logic waitrequest, rtc_installed, batt_lamp, irq_allow, clear_volatile, clear_retained;
   logic reset_mem_stop, scan_start;
   ssr_note_t notes[$];
   int bad_count = 0, checks_done = 0, cycles = 0, seed = 83599, mem_stops = 0;

   // short millisecond so the 1 s relay moves within the run
   ssr_relays #(.MS_DIV(DIV), .OUT_N(16)) ssr_relays_i (
      .ref_clk(ref_clk), .nrst(nrst), .ce(1'b1), .address(address), .read(read),
      .write(write), .byteenable(4'hf), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .batt_low_pin(batt_low_pin), .rtc_err_pin(rtc_err_pin),
      .run(run), .arith(arith), .multi_scan_done(multi_scan_done), .net_param_set(net_param_set),
      .xfer_busy(xfer_busy), .scan_end(scan_end), .out_image(out_image), .pulses(pulses),
      .rtc_installed(rtc_installed), .batt_lamp(batt_lamp), .irq_allow(irq_allow),
      .clear_volatile(clear_volatile), .clear_retained(clear_retained),
      .reset_mem_stop(reset_mem_stop), .scan_start(scan_start), .out_pins_q(out_pins_q)
   );

   always #5 ref_clk = ~ref_clk;
   //===================================================================
   // compare and report
   task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic cmp_rd(input ssr_note_t n, input logic [31:0] got);
      cmp(n.v & n.m, got & n.m);
   endtask
   task automatic stop_test;
      $display("mismatches %0d checks %0d", bad_count, checks_done);
      if (bad_count == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // hang guard: the whole sequence needs well under this many cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         bad_count++;
         stop_test();
      end
   end
   // read data is taken only at the edge that sees waitrequest low
   always @(posedge ref_clk) begin
      if (nrst && read && waitrequest === 1'b0) cmp_rd(notes.pop_front(), readdata);
      if (reset_mem_stop === 1'b1) mem_stops++;
   end
   //===================================================================
   // bus master
   task automatic req(input logic [4:0] a, input logic wr, input logic [31:0] d);
      @(posedge ref_clk);
      address <= a;
      read <= !wr;
      write <= wr;
      writedata <= d;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] v, input logic [31:0] m);
      notes.push_back('{v, m});
      req(a, 1'b0, 32'h0);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // one scan end, then cycles until the next scan start
   task automatic scan_gap(output int n);
      @(posedge ref_clk);
      scan_end <= 1'b1;
      @(posedge ref_clk);
      scan_end <= 1'b0;
      n = 1;
      while (scan_start !== 1'b1 && n < 200) begin
         @(posedge ref_clk);
         n++;
      end
   endtask
   //===================================================================
   // main sequence
   initial begin
      logic [15:0] r;
      int n;
      repeat (3) @(posedge ref_clk);
      nrst <= 1'b1;
      cmp(32'h1, {31'h0, rtc_installed});
      rd(OFS_CTRL, {18'h0, CTRL_RESET}, 32'hffff_ffff);
      r = 16'($random(seed));
      req(OFS_SCAN, 1'b1, {16'h0, r});
      rd(OFS_SCAN, {16'h0, r}, 32'h0000_ffff);
      rd(5'h14, 32'h0, 32'hffff_ffff);
      // every mode bit but rounding, then a stop with memory hold set
      run <= 1'b1;
      xfer_busy <= 1'b1;
      batt_low_pin <= 1'b1;
      out_image <= 16'($random(seed)) | 16'h0001;
      req(OFS_CTRL, 1'b1, 32'h0000_3ffb);
      tick(4);
      cmp(32'h0, {31'h0, batt_lamp});
      cmp(32'h1, {31'h0, irq_allow});
      cmp(32'h3, {30'h0, clear_volatile, clear_retained});
      cmp(32'h0, {16'h0, out_pins_q});
      run <= 1'b0;
      tick(4);
      cmp(32'h0, 32'(mem_stops));
      rd(OFS_CTRL, 32'h0000_2883, 32'h0000_3fff);
      cmp(32'h1, {31'h0, batt_lamp});
      cmp({16'h0, out_image}, {16'h0, out_pins_q});
      // second stop without hold must reset memory
      req(OFS_CTRL, 1'b1, 32'h0);
      run <= 1'b1;
      tick(3);
      cmp(32'h0, {31'h0, irq_allow});
      run <= 1'b0;
      tick(4);
      cmp(32'h1, 32'(mem_stops));
      // all eight flag codes from the instruction unit
      for (int i = 0; i < 8; i++) begin
         @(posedge ref_clk);
         arith <= {1'b1, i[0], i[1], i[2]};
         @(posedge ref_clk);
         arith <= '0;
         rd(OFS_STATUS, {23'h0, 3'(i), 6'h00}, 32'h0000_01c0);
      end
      // done, clock fault and network flag, then write-one clear
      @(posedge ref_clk);
      multi_scan_done <= 1'b1;
      rtc_err_pin <= 1'b1;
      net_param_set <= 1'b1;
      @(posedge ref_clk);
      multi_scan_done <= 1'b0;
      rtc_err_pin <= 1'b0;
      tick(4);
      rd(OFS_STATUS, 32'h0000_0400, 32'h0000_0400);
      rd(OFS_STICKY, 32'h3, 32'h3);
      req(OFS_STICKY, 1'b1, 32'h3);
      rd(OFS_STICKY, 32'h0, 32'h3);
      // fixed scan of 3 ms, then free scan
      req(OFS_SCAN, 1'b1, 32'h3);
      req(OFS_CTRL, 1'b1, 32'h2000);
      scan_gap(n);
      scan_gap(n);
      cmp(32'h1, 32'(n >= 2 * DIV && n <= 3 * DIV + 6));
      req(OFS_CTRL, 1'b1, 32'h0);
      scan_gap(n);
      cmp(32'h1, 32'(n <= 4));
      // clock preset, rounding, frozen display
      req(OFS_CTRL, 1'b1, 32'h1);
      req(OFS_RTC, 1'b1, {15'h0, 11'h005, 6'h28});
      rd(OFS_RTC, {15'h0, 11'h005, 6'h28}, 32'h0001_ffff);
      req(OFS_CTRL, 1'b1, 32'h5);
      tick(3);
      rd(OFS_RTC, {15'h0, 11'h006, 6'h00}, 32'h0001_ffff);
      req(OFS_CTRL, 1'b1, 32'h2);
      tick(10100);
      rd(OFS_RTC, {15'h0, 11'h006, 6'h00}, 32'h0001_ffff);
      req(OFS_CTRL, 1'b1, 32'h0);
      tick(3);
      // exactly one rise of the 1 s relay fell inside the running window
      rd(OFS_RTC, {15'h0, 11'h006, 6'h01}, 32'h0001_ffff);
      tick(2);
      // the minute relay must not move before its 30 s half period
      cmp(32'h0, {31'h0, pulses[3]});
      stop_test();
   end
endmodule
